// ---- hdl/scr_register_bank.sv ----
// register bank of the sensor conditioner with its decoded control outputs
`timescale 1ns/100ps
module scr_register_bank
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  nrst,
	// register access port from the link decoders
	input  wire logic                  regWrite,
	input  wire logic                  regRead,
	input  wire logic [7:0]            regAddr,
	input  wire logic [15:0]           regWdata,
	output logic      [15:0]           regRdata,
	output logic                       regAck,
	// link in use
	input  wire logic                  powerLineLinkActive,
	// results produced by the signal chain
	input  wire logic                  calPressureValid,
	input  wire logic [15:0]           calPressure,
	input  wire logic                  calTemperatureValid,
	input  wire logic [15:0]           calTemperature,
	input  wire logic                  nvProtoReadValid,
	input  wire logic [15:0]           nvProtoReadWord,
	input  wire logic [15:0]           nvBurnCount,
	// decoded controls
	output logic      [7:0]            tempGain,
	output logic      [4:0]            tempChannelSetup,
	output logic      [2:0]            offsetCancelSetup,
	output logic      [1:0]            analogBandwidth,
	output logic      [15:0]           zeroOffsetActive,
	input  wire logic [15:0]           zeroOffsetStored,
	output logic      [3:0]            outputSelect,
	output logic                       nvMemoryEnable,
	output logic                       tempCalBypass,
	output logic                       pressCalBypass,
	output logic      [2:0]            digitalFilter,
	output logic                       referenceInputExt,
	output logic                       resistorExt,
	output logic                       shutdown,
	output logic                       analogEnable,
	output logic                       shutdownLocked,
	output logic      [1:0]            tempCurrent,
	output scr_pkg::scr_alert_type     alertMode,
	output logic                       gainAmpMuxSel,
	output logic      [7:0]            nvProtoWriteAddress,
	output logic      [15:0]           nvProtoWriteWord,
	output logic      [7:0]            nvWordAddress,
	output logic      [15:0]           nvDataWord
);
	import scr_pkg::*;

	// stored registers
	logic [15:0] config_r;          // configuration word
	logic [7:0]  tgain_r;           // temperature gain
	logic [15:0] calp_r;            // calibrated pressure capture
	logic [15:0] calt_r;            // calibrated temperature capture
	logic [4:0]  tsetup_r;          // temperature channel setup
	logic [2:0]  ofscan_r;          // offset cancel setup
	logic [1:0]  abw_r;             // analog bandwidth
	logic [15:0] zovr_r;            // volatile zero offset override
	logic        zsel_r;            // override apply select
	logic [3:0]  outsel_r;          // output pin signal select
	// nonvolatile store support words
	logic [15:0] nvinitA_r;         // nv init words
	logic [15:0] nvinitB_r;
	logic [15:0] nvinitC_r;
	logic [15:0] nvinitD_r;
	logic [7:0]  aux1_r;            // aux controls
	logic [7:0]  aux2_r;
	logic [7:0]  nvctrl_r;          // nv memory control
	logic [7:0]  nvstate_r;         // nv memory state
	logic [7:0]  pwaddr_r;          // prototyping write address
	logic [15:0] pwword_r;          // prototyping write word
	logic [15:0] prword_r;          // prototyping read word
	logic [15:0] nvdata_r;          // nv data word
	logic [7:0]  nvaddr_r;          // nv word address
	// control state and combinational helpers
	logic        lock_r;            // shutdown entered over power-line link
	logic [15:0] rdata_nxt;         // read mux value
	logic        hit_nxt;           // address decodes to a register
	logic [15:0] cfgNext;           // configuration value after a write

	// write strobe for one offset
	// decoded in one place so every register sees the same compare
	function automatic logic wr(input logic [7:0] a);
		wr = regWrite && (regAddr == a);
	endfunction

	// configuration word; once locked the shutdown bit cannot be cleared
	// reserved bit masked here so it is never stored
	always_comb
	begin
		cfgNext = regWdata & CFG_WMASK; // (R11) (R19)
		// the power-line link rides on the output pin, dead in shutdown
		if (lock_r)
			cfgNext[CFG_SHDN_BIT] = 1'b1; // (R13)
	end

	// configuration register
	// no strobe, no change; a write lands on the strobe edge
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			config_r <= RST_WORD; // (R20)
		else if (wr(ADDR_CONFIG))
			config_r <= cfgNext; // (R11)
	end

	// shutdown lock; sticky until reset, only a power cycle frees it
	// the host loses its only path back once the output pin is dead,
	// so a set lock must never be cleared by a later write
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			lock_r <= 1'b0;
		else if (wr(ADDR_CONFIG) && regWdata[CFG_SHDN_BIT] && powerLineLinkActive)
			lock_r <= 1'b1; // (R13)
		else if (config_r[CFG_SHDN_BIT] && powerLineLinkActive)
			lock_r <= 1'b1; // (R13)
	end

	// small analog setup registers; upper write bits dropped, except the override word, which keeps all 16
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tgain_r  <= RST_BYTE; // (R20)
			tsetup_r <= RST_BYTE[4:0]; // (R4)
			ofscan_r <= RST_BYTE[2:0];
			abw_r    <= RST_BYTE[1:0];
			// override starts deselected, stored offset in use
			zsel_r   <= 1'b0;
			outsel_r <= RST_BYTE[3:0];
			// override word is RAM only, lost on every reset
			zovr_r   <= RST_WORD;
		end
		else
		begin
			// full byte kept; only sixteen gain codes matter downstream
			if (wr(ADDR_TGAIN))
				tgain_r <= regWdata[7:0]; // (R1)
			// five setup bits, rest of the byte dropped
			if (wr(ADDR_TSETUP))
				tsetup_r <= regWdata[4:0]; // (R4) (R20)
			// offset cancel setting, three bits
			if (wr(ADDR_OFSCAN))
				ofscan_r <= regWdata[2:0]; // (R5)
			// bandwidth code, two bits
			if (wr(ADDR_ABW))
				abw_r <= regWdata[1:0]; // (R6)
			// apply select, single bit
			if (wr(ADDR_ZSEL))
				zsel_r <= regWdata[0]; // (R8)
			// output pin routing code
			if (wr(ADDR_OUTSEL))
				outsel_r <= regWdata[3:0]; // (R9)
			// whole override word in one access
			if (wr(ADDR_ZOVR))
				zovr_r <= regWdata; // (R7)
		end
	end

	// nonvolatile store support registers
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			// init words
			nvinitA_r <= RST_WORD;
			nvinitB_r <= RST_WORD;
			nvinitC_r <= RST_WORD;
			nvinitD_r <= RST_WORD;
			// aux and store control bytes
			aux1_r    <= RST_BYTE;
			aux2_r    <= RST_BYTE;
			nvctrl_r  <= RST_BYTE;
			nvstate_r <= RST_BYTE;
			// prototyping path
			pwaddr_r  <= RST_BYTE;
			pwword_r  <= RST_WORD;
			// data and address of the store
			nvdata_r  <= RST_WORD;
			nvaddr_r  <= RST_BYTE;
		end
		else
		begin
			// first init word
			if (wr(ADDR_NVINIT_A))
				nvinitA_r <= regWdata;
			// second init word
			if (wr(ADDR_NVINIT_B))
				nvinitB_r <= regWdata;
			// third init word
			if (wr(ADDR_NVINIT_C))
				nvinitC_r <= regWdata;
			// fourth init word
			if (wr(ADDR_NVINIT_D))
				nvinitD_r <= regWdata;
			// aux control one, low byte only
			if (wr(ADDR_AUX1))
				aux1_r <= regWdata[7:0];
			// aux control two, low byte only
			if (wr(ADDR_AUX2))
				aux2_r <= regWdata[7:0];
			// store control byte
			if (wr(ADDR_NVCTRL))
				nvctrl_r <= regWdata[7:0];
			// store state byte, host writable
			if (wr(ADDR_NVSTATE))
				nvstate_r <= regWdata[7:0];
			// prototyping write address
			if (wr(ADDR_PWADDR))
				pwaddr_r <= regWdata[7:0]; // (R10)
			// prototyping write word
			if (wr(ADDR_PWWORD))
				pwword_r <= regWdata; // (R10)
			// data word for the store
			if (wr(ADDR_NVDATA))
				nvdata_r <= regWdata;
			// word address for the store
			if (wr(ADDR_NVADDR))
				nvaddr_r <= regWdata[7:0];
		end
	end

	// result captures; host writes never reach these
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			// results read zero until the first capture
			calp_r   <= RST_WORD;
			calt_r   <= RST_WORD;
			prword_r <= RST_WORD;
		end
		else
		begin
			// newest pressure result wins, older ones are lost
			if (calPressureValid)
				calp_r <= calPressure; // (R2) (R19)
			// newest temperature result
			if (calTemperatureValid)
				calt_r <= calTemperature; // (R3) (R19)
			// word read back from the store
			if (nvProtoReadValid)
				prword_r <= nvProtoReadWord; // (R10)
		end
	end

	// read mux; narrow registers zero-extended
	// reads have no side effects, so a repeated read is harmless
	// the burn count is passed through live and never latched here
	always_comb
	begin
		rdata_nxt = RST_WORD;
		hit_nxt   = 1'b1;
		unique case (regAddr)
			// configuration, reserved bit masked off
			ADDR_CONFIG:   rdata_nxt = config_r & CFG_WMASK; // (R19)
			// gain byte
			ADDR_TGAIN:    rdata_nxt = {8'h00, tgain_r};
			// results captured from the signal chain
			ADDR_CALP:     rdata_nxt = calp_r; // (R2)
			ADDR_CALT:     rdata_nxt = calt_r; // (R3)
			// temperature and offset setup
			ADDR_TSETUP:   rdata_nxt = {11'h000, tsetup_r}; // (R20)
			ADDR_OFSCAN:   rdata_nxt = {13'h0000, ofscan_r};
			// bandwidth and offset override
			ADDR_ABW:      rdata_nxt = {14'h0000, abw_r};
			ADDR_ZOVR:     rdata_nxt = zovr_r;
			ADDR_ZSEL:     rdata_nxt = {15'h0000, zsel_r};
			// output pin routing
			ADDR_OUTSEL:   rdata_nxt = {12'h000, outsel_r};
			// first pair of init words
			ADDR_NVINIT_A: rdata_nxt = nvinitA_r;
			ADDR_NVINIT_B: rdata_nxt = nvinitB_r;
			// aux controls
			ADDR_AUX1:     rdata_nxt = {8'h00, aux1_r};
			ADDR_AUX2:     rdata_nxt = {8'h00, aux2_r};
			// store control and state
			ADDR_NVCTRL:   rdata_nxt = {8'h00, nvctrl_r};
			ADDR_NVSTATE:  rdata_nxt = {8'h00, nvstate_r};
			// prototyping access
			ADDR_PWADDR:   rdata_nxt = {8'h00, pwaddr_r};
			ADDR_PWWORD:   rdata_nxt = pwword_r;
			ADDR_PRWORD:   rdata_nxt = prword_r; // (R10)
			// live burn count
			ADDR_BURNCNT:  rdata_nxt = nvBurnCount;
			// second pair of init words
			ADDR_NVINIT_C: rdata_nxt = nvinitC_r;
			ADDR_NVINIT_D: rdata_nxt = nvinitD_r;
			// data word and word address
			ADDR_NVDATA:   rdata_nxt = nvdata_r;
			ADDR_NVADDR:   rdata_nxt = {8'h00, nvaddr_r};
			// unmapped offsets
			default:       hit_nxt   = 1'b0; // unmapped reads zero
		endcase
	end

	// registered read data and one-cycle acknowledge
	// every strobe is acked, even to read-only or unmapped offsets,
	// so a link decoder never waits on an address it got wrong
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			regRdata <= RST_WORD;
			regAck   <= 1'b0;
		end
		else
		begin
			regAck <= regRead || regWrite; // (R16)
			if (regRead)
				regRdata <= hit_nxt ? rdata_nxt : RST_WORD;
		end
	end

	// decoded controls
	// gain code straight to the temperature amplifier
	assign tempGain            = tgain_r; // (R1)
	// temperature channel pin usage
	assign tempChannelSetup    = tsetup_r;
	// offset cancel setting for the calibration procedure
	assign offsetCancelSetup   = ofscan_r;
	// analog filter choice for the pressure channel
	assign analogBandwidth     = abw_r;
	// override only while selected, else the stored offset
	// switching is immediate, so load the word before the select
	assign zeroOffsetActive    = zsel_r ? zovr_r : zeroOffsetStored; // (R7) (R8)
	// signal routed to the output pin
	assign outputSelect        = outsel_r;
	// store enable is active while its bit is clear
	assign nvMemoryEnable      = !config_r[CFG_NVEN_BIT]; // (R12) zero means enabled
	// raw mode for the temperature channel
	assign tempCalBypass       = config_r[CFG_TBYP_BIT]; // (R12)
	// raw mode for the pressure channel
	assign pressCalBypass      = config_r[CFG_PBYP_BIT];
	// averaging depth code
	assign digitalFilter       = config_r[CFG_DFILT_HI:CFG_DFILT_LO];
	// external reference when set
	assign referenceInputExt   = config_r[CFG_REFSEL_BIT];
	// external current source resistor when set
	assign resistorExt         = config_r[CFG_RESSEL_BIT];
	// shutdown request as stored
	assign shutdown            = config_r[CFG_SHDN_BIT];
	// registers keep answering in shutdown; only analog is gated
	// the serial links need no analog, so they stay awake
	assign analogEnable        = !config_r[CFG_SHDN_BIT]; // (R17)
	// lock flag for the link decoders
	assign shutdownLocked      = lock_r; // (R13)
	// thermistor source current code
	assign tempCurrent         = config_r[CFG_TCUR_HI:CFG_TCUR_LO];
	// alert behaviour code; unused codes passed through as they are
	assign alertMode           = scr_alert_type'(config_r[CFG_ALERT_HI:CFG_ALERT_LO]); // (R15) (R18)
	// amplifier input source select
	assign gainAmpMuxSel       = config_r[CFG_MUX_BIT]; // (R14)
	// prototyping address and word toward the store
	assign nvProtoWriteAddress = pwaddr_r;
	assign nvProtoWriteWord    = pwword_r;
	// word address and data toward the store
	assign nvWordAddress       = nvaddr_r;
	assign nvDataWord          = nvdata_r;
endmodule

// ---- common/scr_pkg.sv ----
// package of register map constants for the sensor conditioner register bank
// What this block does
// (R1) 8-bit gain register at 0x0E, read/write
// (R2) read-only calibrated pressure at 0x0F
// (R3) read-only calibrated temperature at 0x11
// (R4) 5-bit temperature setup at 0x13, resets zero
// (R5) 3-bit offset cancel setup at 0x14
// (R6) 2-bit analog bandwidth select at 0x15
// (R7) 16-bit volatile zero offset override at 0x1A
// (R8) 1-bit override apply select at 0x1C
// (R9) 4-bit output pin signal select at 0x1E
// (R10) prototyping address, write word, read word
// (R11) configuration word 16 bits, all writable except reserved bit 6
// (R12) configuration field layout, bit 15 down to 0
// (R13) shutdown over power-line link cannot be left
// (R14) bit 0 steers amplifier input mux
// (R15) 3-bit alert mode field selects alert behaviour
// (R16) address first, then one or two data bytes
// (R17) shutdown kills analog, serial links keep answering
// (R18) alert codes: interrupt, pwm, four thresholds
// (R19) read-only writes ignored, reserved bit reads zero
// (R20) reset loads power-on values, upper bits zero
package scr_pkg;
	// register offsets
	localparam logic [7:0] ADDR_CONFIG     = 8'h00;
	localparam logic [7:0] ADDR_TGAIN      = 8'h0E;
	localparam logic [7:0] ADDR_CALP       = 8'h0F;
	localparam logic [7:0] ADDR_CALT       = 8'h11;
	localparam logic [7:0] ADDR_TSETUP     = 8'h13;
	localparam logic [7:0] ADDR_OFSCAN     = 8'h14;
	localparam logic [7:0] ADDR_ABW        = 8'h15;
	localparam logic [7:0] ADDR_ZOVR       = 8'h1A;
	localparam logic [7:0] ADDR_ZSEL       = 8'h1C;
	localparam logic [7:0] ADDR_OUTSEL     = 8'h1E;
	localparam logic [7:0] ADDR_NVINIT_A   = 8'h9B;
	localparam logic [7:0] ADDR_NVINIT_B   = 8'h9D;
	localparam logic [7:0] ADDR_AUX1       = 8'h9F;
	localparam logic [7:0] ADDR_AUX2       = 8'hA0;
	localparam logic [7:0] ADDR_NVCTRL     = 8'hA2;
	localparam logic [7:0] ADDR_NVSTATE    = 8'hA3;
	localparam logic [7:0] ADDR_PWADDR     = 8'hA4;
	localparam logic [7:0] ADDR_PWWORD     = 8'hA5;
	localparam logic [7:0] ADDR_PRWORD     = 8'hA7;
	localparam logic [7:0] ADDR_BURNCNT    = 8'hA9;
	localparam logic [7:0] ADDR_NVINIT_C   = 8'hAB;
	localparam logic [7:0] ADDR_NVINIT_D   = 8'hAD;
	localparam logic [7:0] ADDR_NVDATA     = 8'hAF;
	localparam logic [7:0] ADDR_NVADDR     = 8'hB1;
	// configuration field positions
	localparam int CFG_NVEN_BIT     = 15;
	localparam int CFG_TBYP_BIT     = 14;
	localparam int CFG_PBYP_BIT     = 13;
	localparam int CFG_DFILT_HI     = 12;
	localparam int CFG_DFILT_LO     = 10;
	localparam int CFG_REFSEL_BIT   = 9;
	localparam int CFG_RESSEL_BIT   = 8;
	localparam int CFG_SHDN_BIT     = 7;
	localparam int CFG_RSVD_BIT     = 6;
	localparam int CFG_TCUR_HI      = 5;
	localparam int CFG_TCUR_LO      = 4;
	localparam int CFG_ALERT_HI     = 3;
	localparam int CFG_ALERT_LO     = 1;
	localparam int CFG_MUX_BIT      = 0;
	// writable mask of the configuration word, reserved bit cleared
	localparam logic [15:0] CFG_WMASK = 16'hFFBF;
	// reset values
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	// alert mode encodings
	typedef enum logic [2:0]
	{
		ALM_INTR  = 3'h0,
		ALM_PWM   = 3'h1,
		ALM_CASE1 = 3'h2,
		ALM_CASE2 = 3'h3,
		ALM_CASE3 = 3'h4,
		ALM_CASE4 = 3'h5,
		ALM_UNU6  = 3'h6,
		ALM_UNU7  = 3'h7
	} scr_alert_type;
endpackage

// ---- verif/scr_bank_chk_sva.sv ----
// checker of register bank port timing and field decode
`timescale 1ns/100ps
module scr_bank_chk
(
	// clock and reset
	input wire logic			clk,
	input wire logic			nrst,
	// register port
	input wire logic			regWrite,
	input wire logic			regRead,
	input wire logic [7:0]		regAddr,
	input wire logic [15:0]		regWdata,
	input wire logic [15:0]		regRdata,
	input wire logic			regAck,
	// captured result
	input wire logic			calPressureValid,
	input wire logic [15:0]		calPressure,
	// decoded controls
	input wire logic [7:0]		tempGain,
	input wire logic [1:0]		analogBandwidth,
	input wire logic [2:0]		digitalFilter,
	input wire logic			shutdown,
	input wire logic			analogEnable,
	input wire logic			shutdownLocked,
	input wire scr_pkg::scr_alert_type	alertMode,
	input wire logic			gainAmpMuxSel
);
	import scr_pkg::*;
	// one clock domain, so one default clock and disable
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// capture pulse followed at once by a read of the pressure result
	sequence sCapRead;
		calPressureValid ##1 (regRead && regAddr == ADDR_CALP);
	endsequence
	// every strobe is answered exactly one cycle later
	a_ack_after: assert property ((regWrite || regRead) |=> regAck)
		else $error("strobe not acknowledged next cycle");
	a_ack_cause: assert property (regAck |-> $past(regWrite || regRead))
		else $error("acknowledge without a strobe");
	a_gain_load: assert property (regWrite && regAddr == ADDR_TGAIN |=>
		tempGain == $past(regWdata[7:0])) else $error("gain not loaded");
	a_narrow_bw: assert property (regWrite && regAddr == ADDR_ABW |=>
		analogBandwidth == $past(regWdata[1:0])) else $error("bandwidth not loaded");
	a_rsvd_zero: assert property (regRead && regAddr == ADDR_CONFIG |=>
		!regRdata[6]) else $error("reserved bit read as one");
	a_analog_off: assert property (analogEnable != shutdown)
		else $error("analog enable not inverse of shutdown");
	// lock only ever holds with shutdown set, and persists
	a_lock_stays: assert property (shutdownLocked |-> shutdown ##1 shutdownLocked)
		else $error("shutdown lock released");
	a_press_capture: assert property (sCapRead |=> regRdata == $past(calPressure, 2))
		else $error("pressure result not returned");
	a_cfg_fields: assert property (regWrite && regAddr == ADDR_CONFIG |=>
		alertMode == $past(regWdata[3:1]) && gainAmpMuxSel == $past(regWdata[0])
		&& digitalFilter == $past(regWdata[12:10])) else $error("config fields wrong");
endmodule

bind scr_register_bank scr_bank_chk i_chk (.clk, .nrst, .regWrite, .regRead, .regAddr,
	.regWdata, .regRdata, .regAck, .calPressureValid, .calPressure, .tempGain,
	.analogBandwidth, .digitalFilter, .shutdown, .analogEnable, .shutdownLocked,
	.alertMode, .gainAmpMuxSel);

// ---- verif/scr_host_model.sv ----
// host side model issuing register accesses into the bank
`timescale 1ns/100ps
module scr_host_model
(
	// clock
	input wire logic			clk,
	// register port toward the bank
	output logic				regWrite,
	output logic				regRead,
	output logic [7:0]			regAddr,
	output logic [15:0]			regWdata,
	input wire logic [15:0]		regRdata,
	input wire logic			regAck
);
	// idle strobes from time zero
	initial
	begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWdata = 16'h0000;
	end
	// address and data travel together on a one-cycle strobe;
	// gap idles a few cycles to mimic a slow link
	task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
		input int gap, output logic [15:0] q);
		int n;
		n = 0;
		q = 16'hXXXX;
		repeat (gap) @(posedge clk);
		regWrite <= wr;
		regRead <= !wr;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
		regRead <= 1'b0;
		// released lines show a changed pattern, not the old value
		regAddr <= ~a;
		regWdata <= ~d;
		@(posedge clk);
		while (regAck !== 1'b1 && n < 3)
		begin
			@(posedge clk);
			n++;
		end
		if (regAck === 1'b1)
			q = regRdata;
	endtask
endmodule

// ---- verif/testbench.sv ----
// self-checking bench of the sensor conditioner register bank
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin errCount++; \
	$display("BAD %s expected %h seen %h", nm, e, g); end end
module testbench;
	import scr_pkg::*;
	// stimulus and observed signals
	logic clk = 1'b0, nrst = 1'b0, power_line_link = 1'b0, pV = 1'b0, tV = 1'b0, rV = 1'b0;
	logic [15:0] pD = 16'h0000, tD = 16'h0000, rD = 16'h0000, burn = 16'h0000;
	logic regWrite, regRead, regAck, nvMemoryEnable, shutdown, analogEnable;
	logic shutdownLocked, gainAmpMuxSel;
	logic tempCalBypass, pressCalBypass, referenceInputExt, resistorExt;
	logic [4:0] tempChannelSetup;
	logic [3:0] outputSelect;
	logic [2:0] offsetCancelSetup;
	logic [1:0] analogBandwidth;
	logic [7:0] nvProtoWriteAddress, nvWordAddress;
	logic [15:0] nvProtoWriteWord, nvDataWord;
	logic [7:0] regAddr, tempGain;
	logic [15:0] regWdata, regRdata, zeroOffsetActive;
	logic [2:0] digitalFilter;
	logic [1:0] tempCurrent;
	scr_alert_type alertMode;
	int errCount = 0, checkCount = 0, cyc = 0;
	// mapped offsets and the bits each keeps after an all-ones write
	logic [7:0] adr [24] = '{8'h00, 8'h0E, 8'h0F, 8'h11, 8'h13, 8'h14, 8'h15, 8'h1A,
		8'h1C, 8'h1E, 8'h9B, 8'h9D, 8'h9F, 8'hA0, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA7,
		8'hA9, 8'hAB, 8'hAD, 8'hAF, 8'hB1};
	logic [15:0] msk [24] = '{16'hFFBF, 16'h00FF, 16'h0000, 16'h0000, 16'h001F,
		16'h0007, 16'h0003, 16'hFFFF, 16'h0001, 16'h000F, 16'hFFFF, 16'hFFFF, 16'h00FF,
		16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h0000, 16'h0000, 16'hFFFF,
		16'hFFFF, 16'hFFFF, 16'h00FF};
	always #10 clk = ~clk;
	scr_host_model i_host (.clk, .regWrite, .regRead, .regAddr, .regWdata, .regRdata,
		.regAck);
	scr_register_bank i_dut (.clk, .nrst, .regWrite, .regRead, .regAddr, .regWdata,
		.regRdata, .regAck, .powerLineLinkActive(power_line_link), .calPressureValid(pV),
		.calPressure(pD), .calTemperatureValid(tV), .calTemperature(tD),
		.nvProtoReadValid(rV), .nvProtoReadWord(rD), .nvBurnCount(burn), .tempGain,
		.tempChannelSetup, .offsetCancelSetup, .analogBandwidth, .zeroOffsetActive,
		.zeroOffsetStored(16'h1234), .outputSelect, .nvMemoryEnable, .tempCalBypass,
		.pressCalBypass, .digitalFilter, .referenceInputExt, .resistorExt,
		.shutdown, .analogEnable, .shutdownLocked, .tempCurrent, .alertMode,
		.gainAmpMuxSel, .nvProtoWriteAddress, .nvProtoWriteWord, .nvWordAddress,
		.nvDataWord);
	// register access helpers
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		i_host.access(1'b1, a, d, 0, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e, input int g = 0);
		logic [15:0] q;
		i_host.access(1'b0, a, 16'h0000, g, q);
		`CHK("read", e, q)
	endtask
	// verdict, reached from the sequence end or the hang limit
	task finalReport();
		$display("checks %0d mismatches %0d", checkCount, errCount);
		if (errCount == 0 && checkCount > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// hang limit well above the few hundred cycles the sequence needs
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			errCount++;
			finalReport();
		end
	end
	initial
	begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		// power-on values, unmapped read, then all-ones through the width masks
		`CHK("nvEnable", 1'b1, nvMemoryEnable)
		`CHK("analog", 1'b1, analogEnable)
		for (int i = 0; i < 24; i++)
			rd(adr[i], 16'h0000);
		rd(8'h02, 16'h0000);
		for (int i = 0; i < 24; i++)
			wr(adr[i], 16'hFFFF);
		for (int i = 0; i < 24; i++)
			rd(adr[i], msk[i], i % 3);
		`CHK("gain", 8'hFF, tempGain)
		`CHK("setup", 5'h1F, tempChannelSetup)
		`CHK("cancel", 3'h7, offsetCancelSetup)
		`CHK("bandwidth", 2'h3, analogBandwidth)
		`CHK("outSel", 4'hF, outputSelect)
		`CHK("protoAddr", 8'hFF, nvProtoWriteAddress)
		`CHK("protoWord", 16'hFFFF, nvProtoWriteWord)
		`CHK("nvAddr", 8'hFF, nvWordAddress)
		`CHK("nvData", 16'hFFFF, nvDataWord)
		`CHK("bypass", 2'h3, {tempCalBypass, pressCalBypass})
		`CHK("extSel", 2'h3, {referenceInputExt, resistorExt})
		`CHK("offset", 16'hFFFF, zeroOffsetActive)
		wr(ADDR_ZSEL, 16'h0000);
		`CHK("offset", 16'h1234, zeroOffsetActive)
		// field layout of the configuration word and every alert code
		wr(ADDR_CONFIG, 16'h9C2B);
		`CHK("filter", 3'h7, digitalFilter)
		`CHK("current", 2'h2, tempCurrent)
		`CHK("nvEnable", 1'b0, nvMemoryEnable)
		`CHK("extSel", 2'h0, {referenceInputExt, resistorExt})
		`CHK("mux", 1'b1, gainAmpMuxSel)
		for (int m = 0; m < 8; m++)
		begin
			wr(ADDR_CONFIG, 16'(m) << 1);
			`CHK("alert", 3'(m), alertMode)
		end
		// results captured from the signal chain; writes there ignored
		pD <= 16'hC3A5;
		tD <= 16'h5A3C;
		rD <= 16'h7E81;
		burn <= 16'h0042;
		{pV, tV, rV} <= 3'h7;
		@(posedge clk);
		{pV, tV, rV} <= 3'h0;
		rd(ADDR_CALP, 16'hC3A5);
		wr(ADDR_CALP, 16'h0000);
		rd(ADDR_CALP, 16'hC3A5);
		rd(ADDR_CALT, 16'h5A3C);
		rd(ADDR_PRWORD, 16'h7E81);
		rd(ADDR_BURNCNT, 16'h0042);
		// shutdown leaves freely off the power-line link, locks on it
		wr(ADDR_CONFIG, 16'h0080);
		`CHK("analog", 1'b0, analogEnable)
		wr(ADDR_CONFIG, 16'h0000);
		`CHK("wake", 1'b0, shutdown)
		power_line_link <= 1'b1;
		wr(ADDR_CONFIG, 16'h0080);
		wr(ADDR_CONFIG, 16'h0000);
		rd(ADDR_CONFIG, 16'h0080);
		`CHK("locked", 1'b1, shutdownLocked)
		// a second reset is the only way out of the lock
		power_line_link <= 1'b0;
		nrst <= 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		`CHK("unlocked", 1'b0, shutdownLocked)
		rd(ADDR_CONFIG, 16'h0000);
		finalReport();
	end
endmodule
